// ### hdl/torque_limit_consts.vh
// Summary of operation
// - Three output pin groups, each chosen by its own allocation field.
// - One function allocated to several output groups drives each of them.
// - Codes 0 match, 1 rotation, 2 servo ready, 3 torque limiting, 4 brake.
// - Codes 5 index pulse, 6 overtravel, 7 excitation, 8 torque detection.
// - Code A remote output 0, B remote output 1, D position compare, C reserved.
// - Applied torque never exceeds motor maximum; larger limits clamp to it.
// - Internal limiting caps forward and reverse torque only while the matching input is on.
// - Internal limits accept 0 to 350 percent, default 300, act at once.
// - External limits accept 0 to 350 percent, default 100, act at once.
// - Forward input on caps forward torque at smaller of internal and external.
// - Forward input off caps forward torque at the forward external setting.
// - Reverse input on caps reverse torque at smaller of internal and external.
// - Reverse input off caps reverse torque at the reverse external setting.
// - Torque-limiting output is on while output torque is being limited.
// - Torque-limiting output is off while output torque is not limited.
// - Input allocation code 3 selects forward limit, code 4 reverse limit.
`ifndef TORQUE_LIMIT_CONSTS_VH
`define TORQUE_LIMIT_CONSTS_VH

`define REG_OUT_ALLOC    4'h0
`define REG_IN_ALLOC_A   4'h1
`define REG_IN_ALLOC_B   4'h2
`define REG_FWD_INT      4'h3
`define REG_REV_INT      4'h4
`define REG_FWD_EXT      4'h5
`define REG_REV_EXT      4'h6
`define REG_MAX_TORQUE   4'h7
`define REG_REMOTE       4'h8
`define REG_IRQ_STATUS   4'h9
`define REG_IRQ_MASK     4'ha
`define REG_LIVE         4'hb

`define RST_OUT_ALLOC    12'h210
`define RST_IN_ALLOC_A   16'h3210
`define RST_IN_ALLOC_B   4'h4
`define RST_INT_LIMIT    9'h12c
`define RST_EXT_LIMIT    9'h064
`define RST_MAX_TORQUE   9'h12c
`define LIMIT_MAX        9'h15e
`define TORQUE_SCALE     4'ha

`define FN_MATCH         4'h0
`define FN_ROTATION      4'h1
`define FN_SERVO_READY   4'h2
`define FN_TORQUE_LIMIT  4'h3
`define FN_BRAKE         4'h4
`define FN_INDEX_PULSE   4'h5
`define FN_OVERTRAVEL    4'h6
`define FN_EXCITATION    4'h7
`define FN_TORQUE_DETECT 4'h8
`define FN_REMOTE_0      4'ha
`define FN_REMOTE_1      4'hb
`define FN_POS_COMPARE   4'hd

`define IN_FN_FWD_LIMIT  4'h3
`define IN_FN_REV_LIMIT  4'h4

`define IRQ_LIM_RISE     0
`define IRQ_LIM_FALL     1
`define IRQ_FWD_CHANGE   2
`define IRQ_REV_CHANGE   3

`endif

// ### hdl/torque_limit_select_and_output_map.v
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "torque_limit_consts.vh"

module torque_limit_select_and_output_map
(
    input  wire        sys_clk_i,
    input  wire        arst_n_i,
    input  wire [3:0]  reg_addr_i,
    input  wire [15:0] reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output wire [15:0] reg_rdata_o,
    input  wire [4:0]  in_pins_i,
    input  wire        position_or_speed_match_i,
    input  wire        rotation_detected_i,
    input  wire        servo_ready_i,
    input  wire        brake_release_i,
    input  wire        motor_index_pulse_i,
    input  wire        overtravel_i,
    input  wire        motor_excitation_i,
    input  wire        torque_detect_i,
    input  wire        position_compare_i,
    input  wire [15:0] torque_ref_i,
    output wire [15:0] torque_cmd_o,
    output wire        torque_limiting_out_o,
    output wire        fwd_ext_limit_in_o,
    output wire        rev_ext_limit_in_o,
    output wire [2:0]  out_group_o,
    output wire        irq_o
);

    // Limit settings are percent; the torque reference is in tenths of a percent.
    function [9:0] min9;
        input [8:0] a;
        input [8:0] b;
        begin
            min9 = {1'b0, (a < b) ? a : b};
        end
    endfunction

    // Setting writes saturate at the top of the legal range.
    function [8:0] sat_limit;
        input [15:0] v;
        begin
            sat_limit = (v > {7'h00, `LIMIT_MAX}) ? `LIMIT_MAX : v[8:0];
        end
    endfunction

    function [15:0] pct_to_ref;
        input [8:0] pct;
        begin
            pct_to_ref = {7'h00, pct} * {12'h000, `TORQUE_SCALE};
        end
    endfunction

    // One-hot decode of a 4-bit function code onto the 16 function lines.
    function [15:0] decode_fn;
        input [3:0] code;
        begin
            decode_fn = 16'h0001 << code;
        end
    endfunction

    reg  [11:0] out_alloc_q;
    reg  [15:0] in_alloc_a_q;
    reg  [3:0]  in_alloc_b_q;
    reg  [8:0]  fwd_int_q;
    reg  [8:0]  rev_int_q;
    reg  [8:0]  fwd_ext_q;
    reg  [8:0]  rev_ext_q;
    reg  [8:0]  max_torque_q;
    reg  [1:0]  remote_q;
    reg  [3:0]  irq_status_q;
    reg  [3:0]  irq_mask_q;
    reg  [15:0] rdata_q;
    reg  [4:0]  pins_meta_q;
    reg  [4:0]  pins_sync_q;
    reg  [15:0] torque_cmd_q;
    reg         lim_active_q;
    reg         fwd_lim_q;
    reg         rev_lim_q;
    reg  [2:0]  out_group_q;

    wire        wr_hit_out_alloc = reg_wr_i && (reg_addr_i == `REG_OUT_ALLOC);
    wire        wr_hit_in_a      = reg_wr_i && (reg_addr_i == `REG_IN_ALLOC_A);
    wire        wr_hit_in_b      = reg_wr_i && (reg_addr_i == `REG_IN_ALLOC_B);
    wire        wr_hit_fwd_int   = reg_wr_i && (reg_addr_i == `REG_FWD_INT);
    wire        wr_hit_rev_int   = reg_wr_i && (reg_addr_i == `REG_REV_INT);
    wire        wr_hit_fwd_ext   = reg_wr_i && (reg_addr_i == `REG_FWD_EXT);
    wire        wr_hit_rev_ext   = reg_wr_i && (reg_addr_i == `REG_REV_EXT);
    wire        wr_hit_max       = reg_wr_i && (reg_addr_i == `REG_MAX_TORQUE);
    wire        wr_hit_remote    = reg_wr_i && (reg_addr_i == `REG_REMOTE);
    wire        wr_hit_mask      = reg_wr_i && (reg_addr_i == `REG_IRQ_MASK);
    wire        rd_hit_status    = reg_rd_i && (reg_addr_i == `REG_IRQ_STATUS);

    // Setting registers; new values take effect on the very next cycle.
    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            out_alloc_q  <= `RST_OUT_ALLOC;
            in_alloc_a_q <= `RST_IN_ALLOC_A;
            in_alloc_b_q <= `RST_IN_ALLOC_B;
            fwd_int_q    <= `RST_INT_LIMIT;
            rev_int_q    <= `RST_INT_LIMIT;
            fwd_ext_q    <= `RST_EXT_LIMIT;
            rev_ext_q    <= `RST_EXT_LIMIT;
            max_torque_q <= `RST_MAX_TORQUE;
            remote_q     <= 2'h0;
            irq_mask_q   <= 4'h0;
        end
        else
        begin
            if (wr_hit_out_alloc)
            begin
                out_alloc_q <= reg_wdata_i[11:0];
            end
            if (wr_hit_in_a)
            begin
                in_alloc_a_q <= reg_wdata_i;
            end
            if (wr_hit_in_b)
            begin
                in_alloc_b_q <= reg_wdata_i[3:0];
            end
            if (wr_hit_fwd_int)
            begin
                fwd_int_q <= sat_limit(reg_wdata_i);
            end
            if (wr_hit_rev_int)
            begin
                rev_int_q <= sat_limit(reg_wdata_i);
            end
            if (wr_hit_fwd_ext)
            begin
                fwd_ext_q <= sat_limit(reg_wdata_i);
            end
            if (wr_hit_rev_ext)
            begin
                rev_ext_q <= sat_limit(reg_wdata_i);
            end
            if (wr_hit_max)
            begin
                max_torque_q <= sat_limit(reg_wdata_i);
            end
            if (wr_hit_remote)
            begin
                remote_q <= reg_wdata_i[1:0];
            end
            if (wr_hit_mask)
            begin
                irq_mask_q <= reg_wdata_i[3:0];
            end
        end
    end

    // Input pins come from the connector and are synchronised before use.
    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pins_meta_q <= 5'h00;
            pins_sync_q <= 5'h00;
        end
        else
        begin
            pins_meta_q <= in_pins_i;
            pins_sync_q <= pins_meta_q;
        end
    end

    // A function allocated to several pins is the OR of those pins.
    reg         fwd_lim_d;
    reg         rev_lim_d;
    reg  [3:0]  pin_code;
    integer     p;

    always @*
    begin
        fwd_lim_d = 1'b0;
        rev_lim_d = 1'b0;
        pin_code  = 4'h0;
        for (p = 0; p < 5; p = p + 1)
        begin
            if (p == 4)
            begin
                pin_code = in_alloc_b_q;
            end
            else
            begin
                pin_code = in_alloc_a_q[4*p +: 4];
            end
            if (pin_code == `IN_FN_FWD_LIMIT && pins_sync_q[p])
            begin
                fwd_lim_d = 1'b1;
            end
            if (pin_code == `IN_FN_REV_LIMIT && pins_sync_q[p])
            begin
                rev_lim_d = 1'b1;
            end
        end
    end

    // Limit selection for each direction, in percent.
    reg  [9:0]  fwd_cap_pct;
    reg  [9:0]  rev_cap_pct;

    always @*
    begin
        if (fwd_lim_d)
        begin
            fwd_cap_pct = min9(fwd_int_q, fwd_ext_q);
        end
        else
        begin
            fwd_cap_pct = {1'b0, fwd_ext_q};
        end
        if (rev_lim_d)
        begin
            rev_cap_pct = min9(rev_int_q, rev_ext_q);
        end
        else
        begin
            rev_cap_pct = {1'b0, rev_ext_q};
        end
        fwd_cap_pct = min9(fwd_cap_pct[8:0], max_torque_q);
        rev_cap_pct = min9(rev_cap_pct[8:0], max_torque_q);
    end

    wire [15:0] fwd_cap  = pct_to_ref(fwd_cap_pct[8:0]);
    wire [15:0] rev_cap  = pct_to_ref(rev_cap_pct[8:0]);
    wire        ref_neg  = torque_ref_i[15];
    wire [15:0] ref_mag  = ref_neg ? (16'h0000 - torque_ref_i) : torque_ref_i;

    // The most negative reference has a magnitude that does not fit the
    // signed range; it is still above any legal cap, so it clamps correctly.
    reg  [15:0] torque_cmd_d;
    reg         lim_active_d;

    always @*
    begin
        torque_cmd_d = torque_ref_i;
        lim_active_d = 1'b0;
        if (!ref_neg && ref_mag > fwd_cap)
        begin
            torque_cmd_d = fwd_cap;
            lim_active_d = 1'b1;
        end
        else if (ref_neg && ref_mag > rev_cap)
        begin
            torque_cmd_d = 16'h0000 - rev_cap;
            lim_active_d = 1'b1;
        end
    end

    // Function lines indexed by output allocation code; 9, C, E and F stay low.
    wire [15:0] fn_lines = {
        2'b00,
        position_compare_i,
        1'b0,
        remote_q[1],
        remote_q[0],
        1'b0,
        torque_detect_i,
        motor_excitation_i,
        overtravel_i,
        motor_index_pulse_i,
        brake_release_i,
        lim_active_q,
        servo_ready_i,
        rotation_detected_i,
        position_or_speed_match_i};

    reg  [2:0]  out_group_d;
    integer     g;

    always @*
    begin
        out_group_d = 3'h0;
        for (g = 0; g < 3; g = g + 1)
            out_group_d[g] = |(fn_lines & decode_fn(out_alloc_q[4*g +: 4]));
    end

    // Torque path and status registers.
    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            torque_cmd_q <= 16'h0000;
            lim_active_q <= 1'b0;
            fwd_lim_q    <= 1'b0;
            rev_lim_q    <= 1'b0;
            out_group_q  <= 3'h0;
        end
        else
        begin
            torque_cmd_q <= torque_cmd_d;
            lim_active_q <= lim_active_d;
            fwd_lim_q    <= fwd_lim_d;
            rev_lim_q    <= rev_lim_d;
            out_group_q  <= out_group_d;
        end
    end

    // Sticky event flags; an event in the clearing cycle survives the read.
    wire [3:0]  irq_event;

    assign irq_event[`IRQ_LIM_RISE]   = lim_active_d & ~lim_active_q;
    assign irq_event[`IRQ_LIM_FALL]   = ~lim_active_d & lim_active_q;
    assign irq_event[`IRQ_FWD_CHANGE] = fwd_lim_d ^ fwd_lim_q;
    assign irq_event[`IRQ_REV_CHANGE] = rev_lim_d ^ rev_lim_q;

    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            irq_status_q <= 4'h0;
        end
        else if (rd_hit_status)
        begin
            irq_status_q <= irq_event;
        end
        else
        begin
            irq_status_q <= irq_status_q | irq_event;
        end
    end

    // Read data stands for exactly one cycle after the strobe, zero otherwise.
    reg  [15:0] rdata_d;

    always @*
    begin
        case (reg_addr_i)
            `REG_OUT_ALLOC:  rdata_d = {4'h0, out_alloc_q};
            `REG_IN_ALLOC_A: rdata_d = in_alloc_a_q;
            `REG_IN_ALLOC_B: rdata_d = {12'h000, in_alloc_b_q};
            `REG_FWD_INT:    rdata_d = {7'h00, fwd_int_q};
            `REG_REV_INT:    rdata_d = {7'h00, rev_int_q};
            `REG_FWD_EXT:    rdata_d = {7'h00, fwd_ext_q};
            `REG_REV_EXT:    rdata_d = {7'h00, rev_ext_q};
            `REG_MAX_TORQUE: rdata_d = {7'h00, max_torque_q};
            `REG_REMOTE:     rdata_d = {14'h0000, remote_q};
            `REG_IRQ_STATUS: rdata_d = {12'h000, irq_status_q};
            `REG_IRQ_MASK:   rdata_d = {12'h000, irq_mask_q};
            `REG_LIVE:       rdata_d = {3'h0, pins_sync_q, 2'h0, out_group_q,
                                        rev_lim_q, fwd_lim_q, lim_active_q};
            default:         rdata_d = 16'h0000;
        endcase
    end

    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rdata_q <= 16'h0000;
        end
        else if (reg_rd_i)
        begin
            rdata_q <= rdata_d;
        end
        else
        begin
            rdata_q <= 16'h0000;
        end
    end

    assign reg_rdata_o           = rdata_q;
    assign torque_cmd_o          = torque_cmd_q;
    assign torque_limiting_out_o = lim_active_q;
    assign fwd_ext_limit_in_o    = fwd_lim_q;
    assign rev_ext_limit_in_o    = rev_lim_q;
    assign out_group_o           = out_group_q;
    assign irq_o                 = |(irq_status_q & irq_mask_q);

endmodule

`default_nettype wire

// ### bench/torque_limit_chk.sv
`timescale 1ns/1ns
`default_nettype none
`include "torque_limit_consts.vh"
module torque_limit_chk
(
    input wire logic        sys_clk_i,
    input wire logic        arst_n_i,
    input wire logic [3:0]  reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic [15:0] torque_ref_i,
    input wire logic [15:0] torque_cmd_o,
    input wire logic        torque_limiting_out_o,
    input wire logic        fwd_ext_limit_in_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    a_limit_iff_clamp: assert property (
        torque_limiting_out_o == (torque_cmd_o != $past(torque_ref_i)))
        else $error("clamp flag disagrees with command");
    a_cmd_in_range: assert property (
        $signed(torque_cmd_o) <= $signed(16'h0dac) && $signed(torque_cmd_o) >= $signed(16'hf254))
        else $error("command beyond the largest cap");
    a_cmd_follows_ref: assert property (!$past(torque_ref_i[15]) |->
        !torque_cmd_o[15] && torque_cmd_o <= $past(torque_ref_i))
        else $error("command larger than or opposite to reference");
    a_int_saturate: assert property (reg_wr_i && reg_addr_i == `REG_FWD_INT &&
        reg_wdata_i > 16'h015e ##1 reg_rd_i && reg_addr_i == `REG_FWD_INT
        |=> reg_rdata_o == 16'h015e) else $error("limit setting not saturated");
    a_ext_readback: assert property (reg_wr_i && reg_addr_i == `REG_FWD_EXT &&
        reg_wdata_i <= 16'h015e ##1 reg_rd_i && reg_addr_i == `REG_FWD_EXT
        |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("setting not taken at once");
    a_unmapped_zero: assert property (reg_rd_i && reg_addr_i >= 4'hc |=> reg_rdata_o == 16'h0)
        else $error("unmapped read not zero");
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0)
        else $error("read data outside its cycle");
    a_mask_quiet: assert property (reg_wr_i && reg_addr_i == `REG_IRQ_MASK &&
        reg_wdata_i[3:0] == 4'h0 |=> !irq_o) else $error("interrupt with all masked");
    cover property ($rose(torque_limiting_out_o));
    cover property ($rose(fwd_ext_limit_in_o));
    cover property ($rose(irq_o));
endmodule
`default_nettype wire

// ### bench/host_limit_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_limit_model
(
    input  wire logic       sys_clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       fwd_req_i,
    input  wire logic       rev_req_i,
    output var  logic [4:0] pins_o
);
    // Contacts close only on request, on the pins that the default allocation
    // gives to forward and reverse limiting; other pins stay open.
    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pins_o <= 5'h00;
        end
        else
        begin
            pins_o <= {rev_req_i, fwd_req_i, 3'h0};
        end
    end
endmodule
`default_nettype wire

// ### bench/torque_limit_select_and_output_map_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "torque_limit_consts.vh"
module torque_limit_select_and_output_map_bench;
    logic        sys_clk_i    = 1'b0;
    logic        arst_n_i     = 1'b0;
    logic [3:0]  reg_addr_i   = 4'h0;
    logic [15:0] reg_wdata_i  = 16'h0;
    logic        reg_wr_i     = 1'b0;
    logic        reg_rd_i     = 1'b0;
    logic [15:0] torque_ref_i = 16'h0;
    logic [8:0]  flags        = 9'h0;
    logic        fwd_req      = 1'b0;
    logic        rev_req      = 1'b0;
    logic [15:0] rd;
    wire  [15:0] reg_rdata_o;
    wire  [15:0] torque_cmd_o;
    wire  [4:0]  pins;
    wire  [2:0]  out_group_o;
    wire         lim_active;
    wire         fwd_o;
    wire         rev_o;
    wire         irq_o;
    int          bad_count    = 0;
    int          check_count  = 0;
    int          cycles       = 0;

    always #5 sys_clk_i = ~sys_clk_i;

    host_limit_model i_host_limit_model (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
        .fwd_req_i(fwd_req), .rev_req_i(rev_req), .pins_o(pins));

    torque_limit_select_and_output_map i_torque_limit_select_and_output_map (
        .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .in_pins_i(pins), .position_or_speed_match_i(flags[0]),
        .rotation_detected_i(flags[1]), .servo_ready_i(flags[2]), .brake_release_i(flags[3]),
        .motor_index_pulse_i(flags[4]), .overtravel_i(flags[5]),
        .motor_excitation_i(flags[6]), .torque_detect_i(flags[7]),
        .position_compare_i(flags[8]), .torque_ref_i(torque_ref_i),
        .torque_cmd_o(torque_cmd_o), .torque_limiting_out_o(lim_active),
        .fwd_ext_limit_in_o(fwd_o), .rev_ext_limit_in_o(rev_o),
        .out_group_o(out_group_o), .irq_o(irq_o));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
        begin
            $display("TB: PASS");
        end
        else
        begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    // Every request starts 1 ns after an edge, so a strobe is never assigned twice at once.
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [3:0] a);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 rd = reg_rdata_o;
    endtask

    task automatic ref_chk(input logic [15:0] v, input logic [15:0] exp, input logic lim);
        torque_ref_i <= v;
        tick(1);
        check("torque_cmd", torque_cmd_o, exp);
        check("clamp_flag", {15'h0, lim_active}, {15'h0, lim});
    endtask

    task automatic t_defaults();
        logic [3:0]  a [7] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hc};
        logic [15:0] e [7] = '{16'h210, 16'h12c, 16'h12c, 16'h64, 16'h64, 16'h12c, 16'h0};
        for (int i = 0; i < 7; i++)
        begin
            rd_reg(a[i]);
            check("reset_value", rd, e[i]);
        end
    endtask

    task automatic t_cancel();
        ref_chk(16'h0dac, 16'h03e8, 1'b1);
        ref_chk(16'h03e8, 16'h03e8, 1'b0);
        ref_chk(16'hf254, 16'hfc18, 1'b1);
        wr(`REG_FWD_INT, 16'h0032);
        ref_chk(16'h0dac, 16'h03e8, 1'b1);
    endtask

    task automatic t_external();
        fwd_req <= 1'b1;
        rev_req <= 1'b1;
        tick(5);
        check("fwd_in", {15'h0, fwd_o}, 16'h1);
        check("rev_in", {15'h0, rev_o}, 16'h1);
        ref_chk(16'h0dac, 16'h01f4, 1'b1);
        wr(`REG_FWD_INT, 16'h0190);
        rd_reg(`REG_FWD_INT);
        check("fwd_int", rd, 16'h015e);
        wr(`REG_FWD_EXT, 16'h00c8);
        rd_reg(`REG_FWD_EXT);
        check("fwd_ext", rd, 16'h00c8);
        ref_chk(16'h0dac, 16'h07d0, 1'b1);
        wr(`REG_REV_INT, 16'h0014);
        ref_chk(16'hf254, 16'hff38, 1'b1);
        wr(`REG_MAX_TORQUE, 16'h0096);
        ref_chk(16'h0dac, 16'h05dc, 1'b1);
        wr(`REG_MAX_TORQUE, 16'h012c);
        fwd_req <= 1'b0;
        rev_req <= 1'b0;
        tick(5);
        ref_chk(16'h0000, 16'h0000, 1'b0);
    endtask

    // Pin 4 is moved from reverse to forward limiting and back again.
    task automatic t_remap();
        wr(`REG_IN_ALLOC_B, 16'h0003);
        rev_req <= 1'b1;
        tick(5);
        check("remap_fwd", {15'h0, fwd_o}, 16'h1);
        check("remap_rev", {15'h0, rev_o}, 16'h0);
        rd_reg(`REG_LIVE);
        check("live_limits", rd & 16'h0006, 16'h0002);
        rev_req <= 1'b0;
        wr(`REG_IN_ALLOC_B, 16'h0004);
        tick(5);
        check("remap_off", {15'h0, fwd_o}, 16'h0);
    endtask

    task automatic t_map();
        logic [3:0] c [9] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hd};
        for (int i = 0; i < 9; i++)
        begin
            wr(`REG_OUT_ALLOC, {4'h0, c[i], 4'hc, c[i]});
            flags <= 9'h1 << i;
            tick(2);
            check("group_on", {13'h0, out_group_o}, 16'h5);
            flags <= 9'h0;
            tick(2);
            check("group_off", {13'h0, out_group_o}, 16'h0);
        end
        wr(`REG_OUT_ALLOC, 16'h0abc);
        wr(`REG_REMOTE, 16'h1);
        tick(2);
        check("remote_0", {13'h0, out_group_o}, 16'h4);
        wr(`REG_REMOTE, 16'h2);
        tick(2);
        check("remote_1", {13'h0, out_group_o}, 16'h2);
        wr(`REG_OUT_ALLOC, 16'h0c3c);
        ref_chk(16'h0dac, 16'h07d0, 1'b1);
        tick(2);
        check("group_clamp", {13'h0, out_group_o}, 16'h2);
        ref_chk(16'h0000, 16'h0000, 1'b0);
        tick(2);
        check("group_clamp", {13'h0, out_group_o}, 16'h0);
    endtask

    task automatic t_irq();
        wr(`REG_IRQ_MASK, 16'h1);
        rd_reg(`REG_IRQ_STATUS);
        ref_chk(16'h0dac, 16'h07d0, 1'b1);
        tick(1);
        check("irq_rise", {15'h0, irq_o}, 16'h1);
        rd_reg(`REG_IRQ_STATUS);
        check("status", rd & 16'h1, 16'h1);
        check("irq_clear", {15'h0, irq_o}, 16'h0);
        ref_chk(16'h0000, 16'h0000, 1'b0);
        tick(1);
        check("irq_masked", {15'h0, irq_o}, 16'h0);
        wr(`REG_IRQ_MASK, 16'h2);
        tick(1);
        check("irq_fall", {15'h0, irq_o}, 16'h1);
        wr(`REG_IRQ_MASK, 16'h0);
        tick(1);
        check("irq_off", {15'h0, irq_o}, 16'h0);
    endtask

    initial
    begin
        repeat (10) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        tick(1);
        t_defaults();
        t_cancel();
        t_external();
        t_remap();
        t_map();
        t_irq();
        tally_and_finish();
    end
endmodule

bind torque_limit_select_and_output_map torque_limit_chk i_torque_limit_chk (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .torque_ref_i(torque_ref_i), .torque_cmd_o(torque_cmd_o),
    .torque_limiting_out_o(torque_limiting_out_o), .fwd_ext_limit_in_o(fwd_ext_limit_in_o),
    .irq_o(irq_o));
`default_nettype wire
